// ===== design/isp_pkg.sv
// Package: register map, field positions and reset values of the interrupt source block
//Contract
//- Bit 7 of reset control enables two priority levels; kernel software keeps it set.
//- Reset control bits 6 and 5 always read as zero.
//- Reset control holds reset-instruction, watchdog, power-down, power-on and brown-out bits.
//- Each external pin detects rising edge when select is 1, falling when 0.
//- A selected edge on an external pin sets that pin's flag.
//- A cleared pin enable suppresses that pin's interrupt request.
//- Any enabled external interrupt wakes the processor from sleep.
//- After wake-up the core vectors only when global enable is set.
//- External interrupt 0 is always high priority.
//- Ext1 priority from third control bit 6, ext2 from bit 7; 1 is high.
//- In 8-bit mode, timer rollover FFh to 00h sets the overflow flag.
//- In 16-bit mode, rollover FFFFh to 0000h sets the overflow flag.
//- Timer enable is primary bit 5, its priority second control bit 2.
//- Any level change on port B bits 7 to 4 sets primary bit 0.
//- Port change enable is primary bit 3, priority second control bit 0.
//- Taking an interrupt pushes return PC and shadows working, status, bank registers.
package isp_pkg;
  // Byte offsets on the register bus
  localparam logic [3:0] OFS_PRIMARY = 4'h0;
  localparam logic [3:0] OFS_SECOND = 4'h4;
  localparam logic [3:0] OFS_THIRD = 4'h8;
  localparam logic [3:0] OFS_RESET_CTRL = 4'hc;
  // Primary control fields
  localparam int PRI_GLOBAL = 7;
  localparam int PRI_LOW_GLOBAL = 6;
  localparam int PRI_TMR_EN = 5;
  localparam int PRI_EXT0_EN = 4;
  localparam int PRI_PORT_EN = 3;
  localparam int PRI_TMR_FLAG = 2;
  localparam int PRI_EXT0_FLAG = 1;
  localparam int PRI_PORT_FLAG = 0;
  // Second control fields
  localparam int SEC_EDGE0 = 6;
  localparam int SEC_EDGE1 = 5;
  localparam int SEC_EDGE2 = 4;
  localparam int SEC_TMR_PRIO = 2;
  localparam int SEC_PORT_PRIO = 0;
  // Third control fields
  localparam int THR_EXT2_PRIO = 7;
  localparam int THR_EXT1_PRIO = 6;
  localparam int THR_EXT2_EN = 4;
  localparam int THR_EXT1_EN = 3;
  localparam int THR_EXT2_FLAG = 1;
  localparam int THR_EXT1_FLAG = 0;
  // Reset control fields
  localparam int RC_PRIO_EN = 7;
  localparam int RC_RESET_INSTR = 4;
  localparam int RC_WDT_TIMEOUT = 3;
  localparam int RC_POWERDOWN = 2;
  localparam int RC_POWER_ON = 1;
  localparam int RC_BROWNOUT = 0;
  // Reset values and masks
  localparam logic [7:0] PRIMARY_RST = 8'h00;
  localparam logic [7:0] SECOND_RST = 8'h75;
  localparam logic [7:0] THIRD_RST = 8'hc0;
  localparam logic [7:0] RESET_CTRL_RST = 8'h1c;
  localparam logic [7:0] SECOND_MASK = 8'h75;
  localparam logic [7:0] THIRD_MASK = 8'hdb;
  localparam logic [7:0] RESET_CTRL_MASK = 8'h9f;
  // Bus answer state
  typedef enum logic [0:0] {BUS_IDLE = 1'b0, BUS_ANSWER = 1'b1} isp_bus_type;
endpackage

// ===== design/isp_level_watch.sv
// Edge watcher: reports rising and falling changes of a group of synchronous inputs
`timescale 1ns/10ps
module isp_level_watch #(
  parameter int WIDTH = 3
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Watched levels
  input wire logic [WIDTH-1:0] levels,
  // Change indications, valid while ce is high
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  typedef struct packed {
    logic primed;
    logic [WIDTH-1:0] prev;
  } isp_watch_type;

  isp_watch_type state_r;
  isp_watch_type state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    if (ce)
    begin
      state_nxt.prev = levels;
      state_nxt.primed = 1'b1;
    end
  end

  // No edges before the first sample, so a pin high out of reset is not a rise
  assign rise = state_r.primed ? (levels & ~state_r.prev) : '0;
  assign fall = state_r.primed ? (~levels & state_r.prev) : '0;

  always_ff @(posedge mclk)
  begin
    if (rst)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end
endmodule

// ===== design/isp_irq_ctrl.sv
// Interrupt source flags, enables, priority grouping, wake-up and context shadow
`timescale 1ns/10ps
module isp_irq_ctrl #(
  parameter int PC_WIDTH = 21
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Interrupt sources
  input wire logic [2:0] extPins,
  input wire logic [3:0] portBHigh,
  input wire logic [15:0] timerCount,
  input wire logic timerMode16,
  // Reset cause events from the core
  input wire logic resetInstrEvt,
  input wire logic wdtTimeoutEvt,
  input wire logic sleepEnterEvt,
  // Core sequencing and context
  input wire logic sleeping,
  input wire logic irqTake,
  input wire logic irqTakeHigh,
  input wire logic irqReturn,
  input wire logic irqReturnHigh,
  input wire logic [PC_WIDTH-1:0] returnPc,
  input wire logic [7:0] workingReg,
  input wire logic [7:0] statusReg,
  input wire logic [7:0] bankSelectReg,
  // Requests and context outputs
  output logic highIrqReq,
  output logic lowIrqReq,
  output logic priorityLevelsEnable,
  output logic wakeUp,
  output logic vectorBranch,
  output logic stackPush,
  output logic [PC_WIDTH-1:0] stackPc,
  output logic [7:0] shadowWorking,
  output logic [7:0] shadowStatus,
  output logic [7:0] shadowBank
);
  typedef struct packed {
    isp_pkg::isp_bus_type bus;
    logic waitReq;
    logic [31:0] rdata;
    logic [7:0] primary;
    logic [7:0] second;
    logic [7:0] third;
    logic [7:0] resetCtrl;
    logic primed;
    logic [15:0] prevCount;
    logic highReq;
    logic lowReq;
    logic wake;
    logic vector;
    logic push;
    logic [PC_WIDTH-1:0] pc;
    logic [7:0] shW;
    logic [7:0] shS;
    logic [7:0] shB;
  } isp_ctrl_type;

  isp_ctrl_type state_r;
  isp_ctrl_type state_nxt;

  logic [2:0] extRise;
  logic [2:0] extFall;
  logic [3:0] portRise;
  logic [3:0] portFall;

  isp_level_watch #(.WIDTH(3)) extWatch (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .levels(extPins),
    .rise(extRise),
    .fall(extFall)
  );

  isp_level_watch #(.WIDTH(4)) portWatch (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .levels(portBHigh),
    .rise(portRise),
    .fall(portFall)
  );

  // Rollover of the low bits of a counter from all ones to zero
  function automatic logic isp_wrap(input logic [15:0] prev, input logic [15:0] cur,
                                    input logic wide);
    if (wide)
      isp_wrap = (prev == 16'hffff) && (cur == 16'h0000);
    else
      isp_wrap = (prev[7:0] == 8'hff) && (cur[7:0] == 8'h00);
  endfunction

  // Register read view, unmapped offsets read zero
  function automatic logic [7:0] isp_view(input isp_ctrl_type s, input logic [3:0] ofs);
    unique case (ofs)
      isp_pkg::OFS_PRIMARY: isp_view = s.primary;
      isp_pkg::OFS_SECOND: isp_view = s.second & isp_pkg::SECOND_MASK;
      isp_pkg::OFS_THIRD: isp_view = s.third & isp_pkg::THIRD_MASK;
      isp_pkg::OFS_RESET_CTRL: isp_view = s.resetCtrl & isp_pkg::RESET_CTRL_MASK;
      default: isp_view = 8'h00;
    endcase
  endfunction

  logic [2:0] edgeSel;
  logic [2:0] extEvt;
  logic tmrEvt;
  logic portEvt;
  logic wrAccept;
  logic [7:0] wByte;
  logic [3:0] pend;
  logic [3:0] hiMask;
  logic [4:0] pendAll;
  logic [4:0] prioAll;
  logic priority_levels_enable;
  logic global_irq_enable;

  always_comb
  begin
    edgeSel = {state_r.second[isp_pkg::SEC_EDGE2], state_r.second[isp_pkg::SEC_EDGE1],
               state_r.second[isp_pkg::SEC_EDGE0]};
    extEvt = (edgeSel & extRise) | (~edgeSel & extFall);
    tmrEvt = state_r.primed &&
             isp_wrap(state_r.prevCount, timerCount, timerMode16);
    portEvt = |(portRise | portFall);
    wrAccept = write && (state_r.bus == isp_pkg::BUS_ANSWER) && byteenable[0];
    wByte = writedata[7:0];
    priority_levels_enable = state_r.resetCtrl[isp_pkg::RC_PRIO_EN];
    global_irq_enable = state_r.primary[isp_pkg::PRI_GLOBAL];
    // Sources: ext0, ext1, ext2, timer, port change; flag AND enable
    pendAll = {state_r.primary[isp_pkg::PRI_PORT_FLAG] & state_r.primary[isp_pkg::PRI_PORT_EN],
               state_r.primary[isp_pkg::PRI_TMR_FLAG] & state_r.primary[isp_pkg::PRI_TMR_EN],
               state_r.third[isp_pkg::THR_EXT2_FLAG] & state_r.third[isp_pkg::THR_EXT2_EN],
               state_r.third[isp_pkg::THR_EXT1_FLAG] & state_r.third[isp_pkg::THR_EXT1_EN],
               state_r.primary[isp_pkg::PRI_EXT0_FLAG] &
               state_r.primary[isp_pkg::PRI_EXT0_EN]};
    prioAll = {state_r.second[isp_pkg::SEC_PORT_PRIO], state_r.second[isp_pkg::SEC_TMR_PRIO],
               state_r.third[isp_pkg::THR_EXT2_PRIO], state_r.third[isp_pkg::THR_EXT1_PRIO],
               1'b1};
    pend = pendAll[4:1];
    hiMask = prioAll[4:1];

    state_nxt = state_r;
    if (ce)
    begin
      // Bus: one wait cycle, then the answer cycle where write lands
      state_nxt.waitReq = 1'b1;
      state_nxt.bus = isp_pkg::BUS_IDLE;
      if (state_r.bus == isp_pkg::BUS_IDLE && (read || write))
      begin
        state_nxt.bus = isp_pkg::BUS_ANSWER;
        state_nxt.waitReq = 1'b0;
        state_nxt.rdata = {24'h000000, isp_view(state_r, address)};
      end

      // Software writes; flags written here can still be set by an event below
      if (wrAccept)
      begin
        unique case (address)
          isp_pkg::OFS_PRIMARY: state_nxt.primary = wByte;
          isp_pkg::OFS_SECOND: state_nxt.second = wByte & isp_pkg::SECOND_MASK;
          isp_pkg::OFS_THIRD: state_nxt.third = wByte & isp_pkg::THIRD_MASK;
          isp_pkg::OFS_RESET_CTRL:
          begin
            state_nxt.resetCtrl[isp_pkg::RC_PRIO_EN] = wByte[isp_pkg::RC_PRIO_EN];
            state_nxt.resetCtrl[isp_pkg::RC_RESET_INSTR] = wByte[isp_pkg::RC_RESET_INSTR];
            state_nxt.resetCtrl[isp_pkg::RC_POWER_ON] = wByte[isp_pkg::RC_POWER_ON];
            state_nxt.resetCtrl[isp_pkg::RC_BROWNOUT] = wByte[isp_pkg::RC_BROWNOUT];
          end
          default: ;
        endcase
      end

      // Event flags: set wins over a software clear, never cleared by hardware
      if (extEvt[0])
        state_nxt.primary[isp_pkg::PRI_EXT0_FLAG] = 1'b1;
      if (extEvt[1])
        state_nxt.third[isp_pkg::THR_EXT1_FLAG] = 1'b1;
      if (extEvt[2])
        state_nxt.third[isp_pkg::THR_EXT2_FLAG] = 1'b1;
      if (tmrEvt)
        state_nxt.primary[isp_pkg::PRI_TMR_FLAG] = 1'b1;
      if (portEvt)
        state_nxt.primary[isp_pkg::PRI_PORT_FLAG] = 1'b1;

      // Reset cause events from the core, active-low cause bits
      if (resetInstrEvt)
        state_nxt.resetCtrl[isp_pkg::RC_RESET_INSTR] = 1'b0;
      if (wdtTimeoutEvt)
        state_nxt.resetCtrl[isp_pkg::RC_WDT_TIMEOUT] = 1'b0;
      if (sleepEnterEvt)
        state_nxt.resetCtrl[isp_pkg::RC_POWERDOWN] = 1'b0;

      state_nxt.prevCount = timerCount;
      state_nxt.primed = 1'b1;

      // Priority grouping; ext0 always rides in the high group
      if (priority_levels_enable)
      begin
        state_nxt.highReq = global_irq_enable && (pendAll[0] || |(pend & hiMask));
        state_nxt.lowReq = global_irq_enable && state_r.primary[isp_pkg::PRI_LOW_GLOBAL] &&
                           |(pend & ~hiMask);
      end
      else
      begin
        state_nxt.highReq = global_irq_enable && |pendAll;
        state_nxt.lowReq = 1'b0;
      end

      // Wake-up needs only flag and enable; vectoring also needs global enable
      state_nxt.wake = sleeping && |pendAll;
      state_nxt.vector = sleeping && |pendAll && global_irq_enable;

      // Interrupt taken: push return address, shadow core context
      state_nxt.push = irqTake;
      if (irqTake)
      begin
        state_nxt.pc = returnPc;
        state_nxt.shW = workingReg;
        state_nxt.shS = statusReg;
        state_nxt.shB = bankSelectReg;
        // Mask further entries of the same level until return
        if (priority_levels_enable && !irqTakeHigh)
          state_nxt.primary[isp_pkg::PRI_LOW_GLOBAL] = 1'b0;
        else
          state_nxt.primary[isp_pkg::PRI_GLOBAL] = 1'b0;
      end
      else if (irqReturn)
      begin
        if (priority_levels_enable && !irqReturnHigh)
          state_nxt.primary[isp_pkg::PRI_LOW_GLOBAL] = 1'b1;
        else
          state_nxt.primary[isp_pkg::PRI_GLOBAL] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_r <= '0;
      state_r.waitReq <= 1'b1;
      state_r.primary <= isp_pkg::PRIMARY_RST;
      state_r.second <= isp_pkg::SECOND_RST;
      state_r.third <= isp_pkg::THIRD_RST;
      state_r.resetCtrl <= isp_pkg::RESET_CTRL_RST;
    end
    else
      state_r <= state_nxt;
  end

  assign readdata = state_r.rdata;
  assign waitrequest = state_r.waitReq;
  assign highIrqReq = state_r.highReq;
  assign lowIrqReq = state_r.lowReq;
  assign priorityLevelsEnable = state_r.resetCtrl[isp_pkg::RC_PRIO_EN];
  assign wakeUp = state_r.wake;
  assign vectorBranch = state_r.vector;
  assign stackPush = state_r.push;
  assign stackPc = state_r.pc;
  assign shadowWorking = state_r.shW;
  assign shadowStatus = state_r.shS;
  assign shadowBank = state_r.shB;
endmodule

// ===== test/isp_irq_ctrl_props.sv
// Concurrent checks on the ports of the interrupt source block
`timescale 1ns/10ps
module isp_irq_ctrl_props #(
  parameter int PC_WIDTH = 21
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register bus
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Core side
  input wire logic sleeping,
  input wire logic irqTake,
  input wire logic [PC_WIDTH-1:0] returnPc,
  input wire logic [7:0] workingReg,
  input wire logic lowIrqReq,
  input wire logic priorityLevelsEnable,
  input wire logic wakeUp,
  input wire logic vectorBranch,
  input wire logic stackPush,
  input wire logic [PC_WIDTH-1:0] stackPc,
  input wire logic [7:0] shadowWorking
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  logic rcWrite;
  assign rcWrite = write && !waitrequest && byteenable[0] && address == isp_pkg::OFS_RESET_CTRL;
  sequence s_answer;
    !waitrequest ##1 waitrequest;
  endsequence
  sequence s_push;
    stackPush ##1 !stackPush;
  endsequence
  a_bus_answer: assert property ((read || write) && waitrequest |=> s_answer)
    else $error("bus answer not a single cycle after request");
  a_reserved_zero: assert property (read && !waitrequest && address == isp_pkg::OFS_RESET_CTRL
    |-> readdata[6:5] == 2'b00)
    else $error("reserved reset control bits read nonzero");
  a_prio_source: assert property ($changed(priorityLevelsEnable)
    |-> $past(rcWrite) || $past(rcWrite, 2))
    else $error("priority enable changed without a write");
  a_prio_value: assert property (rcWrite ##1 1'b1 |=> priorityLevelsEnable == $past(writedata[7], 2))
    else $error("priority enable does not follow written bit");
  a_low_gate: assert property (lowIrqReq |-> priorityLevelsEnable || $past(priorityLevelsEnable))
    else $error("low request while priority levels disabled");
  a_push_take: assert property (irqTake |=> s_push)
    else $error("take not followed by one push pulse");
  a_push_cause: assert property (stackPush |-> $past(irqTake))
    else $error("push without a take");
  a_shadow_load: assert property (irqTake
    |=> stackPc == $past(returnPc) && shadowWorking == $past(workingReg))
    else $error("context not captured at take");
  a_wake_sleep: assert property (wakeUp |-> $past(sleeping))
    else $error("wake while not asleep");
  a_vector_wake: assert property (vectorBranch |-> wakeUp)
    else $error("vector without wake");
endmodule
bind isp_irq_ctrl isp_irq_ctrl_props #(.PC_WIDTH(PC_WIDTH)) u_props (.mclk(mclk), .rst(rst),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .sleeping(sleeping), .irqTake(irqTake), .returnPc(returnPc), .workingReg(workingReg),
  .lowIrqReq(lowIrqReq), .priorityLevelsEnable(priorityLevelsEnable), .wakeUp(wakeUp),
  .vectorBranch(vectorBranch), .stackPush(stackPush), .stackPc(stackPc),
  .shadowWorking(shadowWorking));

// ===== test/isp_core_model.sv
// Core-side model: sleep level, interrupt take and return with changing context
`timescale 1ns/10ps
module isp_core_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bench controls
  input wire logic sleepReq,
  input wire logic takeEn,
  // Requests from the block
  input wire logic highIrqReq,
  input wire logic lowIrqReq,
  // Core sequencing and context
  output logic sleeping,
  output logic irqTake,
  output logic irqTakeHigh,
  output logic irqReturn,
  output logic [20:0] returnPc,
  output logic [7:0] workingReg
);
  logic [2:0] busy;
  always_ff @(posedge mclk)
  begin
    irqTake <= 1'b0;
    irqReturn <= 1'b0;
    sleeping <= sleepReq && !rst;
    if (rst)
    begin
      busy <= 3'h0;
      irqTakeHigh <= 1'b0;
      returnPc <= 21'h0;
      workingReg <= 8'h0;
    end
    else if (busy != 3'h0)
    begin
      busy <= busy - 3'h1;
      irqReturn <= busy == 3'h1;
    end
    else if (takeEn && (highIrqReq || lowIrqReq))
    begin
      irqTake <= 1'b1;
      irqTakeHigh <= highIrqReq;
      busy <= 3'h6;
      // Fresh context each take, so a stale shadow cannot pass
      returnPc <= returnPc + 21'h1a3;
      workingReg <= workingReg + 8'h35;
    end
  end
endmodule

// ===== test/tb_isp_irq_ctrl.sv
// Self-checking bench for the interrupt source block
`timescale 1ns/10ps
module tb_isp_irq_ctrl;
  logic mclk, rst, read, write, waitrequest, timerMode16, sleepReq, takeEn, sleeping;
  logic resetInstrEvt, wdtTimeoutEvt, sleepEnterEvt, irqTake, irqTakeHigh, irqReturn;
  logic highIrqReq, lowIrqReq, priorityLevelsEnable, wakeUp, vectorBranch, stackPush;
  logic [3:0] address, be, portBHigh;
  logic [31:0] writedata, readdata;
  logic [2:0] extPins;
  logic [15:0] timerCount;
  logic [20:0] returnPc, stackPc;
  logic [7:0] workingReg, shadowWorking, shadowStatus, shadowBank;
  int errTotal = 0;
  int checkCount = 0;
  isp_irq_ctrl DUT (.mclk(mclk), .rst(rst), .ce(1'b1), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(be), .readdata(readdata),
    .waitrequest(waitrequest), .extPins(extPins), .portBHigh(portBHigh),
    .timerCount(timerCount), .timerMode16(timerMode16), .resetInstrEvt(resetInstrEvt),
    .wdtTimeoutEvt(wdtTimeoutEvt), .sleepEnterEvt(sleepEnterEvt), .sleeping(sleeping),
    .irqTake(irqTake), .irqTakeHigh(irqTakeHigh), .irqReturn(irqReturn),
    .irqReturnHigh(irqTakeHigh), .returnPc(returnPc), .workingReg(workingReg),
    .statusReg(~workingReg), .bankSelectReg(workingReg ^ 8'h5a), .highIrqReq(highIrqReq),
    .lowIrqReq(lowIrqReq), .priorityLevelsEnable(priorityLevelsEnable), .wakeUp(wakeUp),
    .vectorBranch(vectorBranch), .stackPush(stackPush), .stackPc(stackPc),
    .shadowWorking(shadowWorking), .shadowStatus(shadowStatus), .shadowBank(shadowBank));
  isp_core_model core (.mclk(mclk), .rst(rst), .sleepReq(sleepReq), .takeEn(takeEn),
    .highIrqReq(highIrqReq), .lowIrqReq(lowIrqReq), .sleeping(sleeping), .irqTake(irqTake),
    .irqTakeHigh(irqTakeHigh), .irqReturn(irqReturn), .returnPc(returnPc),
    .workingReg(workingReg));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      errTotal++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Request held until waitrequest is sampled low, then released
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= {24'h0, d};
    do @(posedge mclk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h0, e});
  endtask
  task automatic req(input logic h, input logic l);
    tick(3);
    chk({30'h0, highIrqReq, lowIrqReq}, {30'h0, h, l});
  endtask
  task automatic pulse(input int k);
    resetInstrEvt <= k == 0;
    wdtTimeoutEvt <= k == 1;
    sleepEnterEvt <= k == 2;
    tick(1);
    {resetInstrEvt, wdtTimeoutEvt, sleepEnterEvt} <= 3'h0;
    tick(1);
  endtask
  task automatic t_regs;
    rd(isp_pkg::OFS_PRIMARY, isp_pkg::PRIMARY_RST);
    rd(isp_pkg::OFS_SECOND, isp_pkg::SECOND_RST);
    rd(isp_pkg::OFS_THIRD, isp_pkg::THIRD_RST);
    rd(isp_pkg::OFS_RESET_CTRL, isp_pkg::RESET_CTRL_RST);
    rd(4'h2, 8'h00);
    wr(isp_pkg::OFS_RESET_CTRL, 8'hff);
    rd(isp_pkg::OFS_RESET_CTRL, 8'h9f);
    be <= 4'h0;
    wr(isp_pkg::OFS_RESET_CTRL, 8'h00);
    be <= 4'h1;
    rd(isp_pkg::OFS_RESET_CTRL, 8'h9f);
    wr(isp_pkg::OFS_RESET_CTRL, 8'h00);
    rd(isp_pkg::OFS_RESET_CTRL, 8'h0c);
    pulse(1);
    pulse(2);
    wr(isp_pkg::OFS_RESET_CTRL, 8'h90);
    pulse(0);
    rd(isp_pkg::OFS_RESET_CTRL, 8'h80);
  endtask
  task automatic t_ext;
    for (int p = 0; p < 3; p++)
      for (int s = 0; s < 2; s++)
      begin
        wr(isp_pkg::OFS_SECOND, s ? 8'h75 : 8'h05);
        extPins <= s ? 3'h7 : 3'h0;
        tick(3);
        wr(isp_pkg::OFS_PRIMARY, 8'h00);
        wr(isp_pkg::OFS_THIRD, 8'hc0);
        extPins[p] <= !s;
        tick(3);
        rd(isp_pkg::OFS_PRIMARY, 8'h00);
        rd(isp_pkg::OFS_THIRD, 8'hc0);
        extPins[p] <= s[0];
        tick(3);
        rd(p ? isp_pkg::OFS_THIRD : isp_pkg::OFS_PRIMARY, p ? 8'hc0 | 8'(p) : 8'h02);
        req(1'b0, 1'b0);
      end
  endtask
  task automatic t_prio;
    wr(isp_pkg::OFS_PRIMARY, 8'hc2);
    wr(isp_pkg::OFS_THIRD, 8'h8b);
    req(1'b0, 1'b1);
    wr(isp_pkg::OFS_THIRD, 8'h4b);
    req(1'b1, 1'b0);
    wr(isp_pkg::OFS_THIRD, 8'h93);
    req(1'b1, 1'b0);
    wr(isp_pkg::OFS_THIRD, 8'h03);
    wr(isp_pkg::OFS_PRIMARY, 8'hd2);
    req(1'b1, 1'b0);
    wr(isp_pkg::OFS_PRIMARY, 8'h82);
    wr(isp_pkg::OFS_THIRD, 8'h13);
    wr(isp_pkg::OFS_RESET_CTRL, 8'h00);
    req(1'b1, 1'b0);
    wr(isp_pkg::OFS_RESET_CTRL, 8'h80);
    wr(isp_pkg::OFS_THIRD, 8'hc0);
  endtask
  task automatic roll(input logic m, input logic [15:0] a, input logic [15:0] b,
                      input logic [7:0] e);
    timerMode16 <= m;
    timerCount <= a;
    tick(2);
    wr(isp_pkg::OFS_PRIMARY, 8'h00);
    timerCount <= b;
    tick(3);
    rd(isp_pkg::OFS_PRIMARY, e);
  endtask
  task automatic t_timer;
    roll(1'b1, 16'h00ff, 16'h0100, 8'h00);
    roll(1'b1, 16'hffff, 16'h0000, 8'h04);
    roll(1'b0, 16'h00fe, 16'h00ff, 8'h00);
    roll(1'b0, 16'h12ff, 16'h1300, 8'h04);
    wr(isp_pkg::OFS_PRIMARY, 8'he4);
    req(1'b1, 1'b0);
    wr(isp_pkg::OFS_SECOND, 8'h71);
    req(1'b0, 1'b1);
  endtask
  task automatic t_port;
    for (int i = 0; i < 4; i++)
    begin
      wr(isp_pkg::OFS_PRIMARY, 8'h00);
      portBHigh[i] <= ~portBHigh[i];
      tick(3);
      rd(isp_pkg::OFS_PRIMARY, 8'h01);
    end
    wr(isp_pkg::OFS_PRIMARY, 8'hc9);
    wr(isp_pkg::OFS_SECOND, 8'h74);
    req(1'b0, 1'b1);
    wr(isp_pkg::OFS_SECOND, 8'h75);
    req(1'b1, 1'b0);
  endtask
  task automatic t_wake;
    wr(isp_pkg::OFS_PRIMARY, 8'h00);
    extPins <= 3'h0;
    sleepReq <= 1'b1;
    tick(2);
    extPins[1] <= 1'b1;
    req(1'b0, 1'b0);
    chk(wakeUp, 1'b0);
    wr(isp_pkg::OFS_THIRD, 8'hc9);
    req(1'b0, 1'b0);
    chk({wakeUp, vectorBranch}, 2'b10);
    wr(isp_pkg::OFS_PRIMARY, 8'h80);
    req(1'b1, 1'b0);
    chk(vectorBranch, 1'b1);
    sleepReq <= 1'b0;
    takeEn <= 1'b1;
    for (int i = 0; i < 20 && stackPush !== 1'b1; i++) @(posedge mclk);
    takeEn <= 1'b0;
    chk(stackPush, 1'b1);
    chk({stackPc, shadowWorking}, {returnPc, workingReg});
    chk({shadowStatus, shadowBank}, {~workingReg, workingReg ^ 8'h5a});
    wr(isp_pkg::OFS_THIRD, 8'hc8);
  endtask
  task automatic end_of_test;
    $display("Checks %0d errors %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    {rst, read, write, timerMode16, sleepReq, takeEn} = 6'h20;
    {resetInstrEvt, wdtTimeoutEvt, sleepEnterEvt} = 3'h0;
    {address, writedata, be} = {4'h0, 32'h0, 4'h1};
    {portBHigh, extPins, timerCount} = {4'h0, 3'h0, 16'h0};
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_regs;
    t_ext;
    t_prio;
    t_timer;
    t_port;
    t_wake;
    end_of_test;
  end
  // Cuts a hang short; the full run needs well under this
  initial
  begin
    repeat (20000) @(posedge mclk);
    errTotal++;
    end_of_test;
  end
endmodule
